// ### dram_pm_pkg.sv
package dram_pm_pkg;

   // ---------------------------------------------------------------
   // Clock and timing
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_PS = 40000;

   localparam int ACT_GAP_NS = 10;
   localparam int PRE_GAP_NS = 10;
   localparam int REF_GAP_NS = 10;
   localparam int MRS_GAP_NS = 20;
   localparam int READ_DONE_NS = 200;
   localparam int WRITE_DONE_NS = 300;
   localparam int CMD_DISABLE_NS = 20;
   localparam int MODE_UPDATE_NS = 40;
   localparam int PD_EXIT_NS = 20;
   localparam int SR_EXIT_NS = 400;
   localparam int PULSE_MIN_NS = 20;
   localparam int PD_MAX_NS = 9000;
   localparam int SUPPLY_WAIT_NS = 100;
   localparam int SUPPLY_OFF_MIN_NS = 1000;
   localparam int HIB_LOW_NS = 100;
   localparam int PLL_LOCK_NS = 80000;
   localparam int HIB_EXIT_NS = 500000;
   localparam int HIB_HOLD_NS = 200000;

   // Least times round up, longest times round down, never below one cycle
   function automatic int cyc_min(input int ns);
      int c;
      c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
      return (c < 1) ? 1 : c;
   endfunction

   function automatic int cyc_max(input int ns);
      int c;
      c = (ns * 1000) / CLK_PERIOD_PS;
      return (c < 1) ? 1 : c;
   endfunction

   localparam int ACT_GAP_CYC = cyc_min(ACT_GAP_NS);
   localparam int PRE_GAP_CYC = cyc_min(PRE_GAP_NS);
   localparam int REF_GAP_CYC = cyc_min(REF_GAP_NS);
   localparam int MRS_GAP_CYC = cyc_min(MRS_GAP_NS);
   localparam int READ_DONE_CYC = cyc_min(READ_DONE_NS);
   localparam int WRITE_DONE_CYC = cyc_min(WRITE_DONE_NS);
   localparam int CMD_DISABLE_CYC = cyc_min(CMD_DISABLE_NS);
   localparam int MODE_UPDATE_CYC = cyc_min(MODE_UPDATE_NS);
   localparam int PD_EXIT_CYC = cyc_min(PD_EXIT_NS);
   localparam int SR_EXIT_CYC = cyc_min(SR_EXIT_NS);
   localparam int PULSE_MIN_CYC = cyc_min(PULSE_MIN_NS);
   localparam int PD_MAX_CYC = cyc_max(PD_MAX_NS);
   localparam int SUPPLY_WAIT_CYC = cyc_min(SUPPLY_WAIT_NS);
   localparam int SUPPLY_OFF_MIN_CYC = cyc_min(SUPPLY_OFF_MIN_NS);
   localparam int HIB_LOW_CYC = cyc_min(HIB_LOW_NS);
   localparam int PLL_LOCK_CYC = cyc_min(PLL_LOCK_NS);
   localparam int HIB_EXIT_CYC = cyc_min(HIB_EXIT_NS);
   localparam int HIB_HOLD_CYC = cyc_min(HIB_HOLD_NS);

   // ---------------------------------------------------------------
   // Register map (byte offsets) and fields
   // ---------------------------------------------------------------
   localparam logic [11:0] OP_OFFSET = 12'h000;
   localparam logic [11:0] ARG_OFFSET = 12'h004;
   localparam logic [11:0] CFG_OFFSET = 12'h008;
   localparam logic [11:0] STATUS_OFFSET = 12'h00C;
   localparam logic [15:0] ARG_RESET = 16'h0000;
   localparam logic [3:0] CFG_RESET = 4'h0;
   localparam int CFG_LOW_POWER_BIT = 0;
   localparam int CFG_PLL_OFF_BIT = 1;
   localparam int CFG_CHAN_LSB = 2;
   localparam int STATUS_BUSY_BIT = 16;
   localparam int STATUS_ERR_BIT = 17;
   localparam int STATUS_SUPPLY_BIT = 18;

   // Mode register writes: address in arg[15:12], operand in arg[11:0]
   localparam logic [15:0] MR7_HIBERNATE_ARG = 16'h7002;
   localparam logic [15:0] MODE_REGISTER_TWELVE_SUPPLY_OFF_ARG = 16'hC001;
   localparam logic [1:0] BOTH_CHANNELS = 2'h3;

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef enum logic [3:0] {
      OP_NONE = 4'h0,
      OP_ACTIVATE = 4'h1,
      OP_PRECHARGE = 4'h2,
      OP_REFRESH = 4'h3,
      OP_MODE_WRITE = 4'h4,
      OP_READ = 4'h5,
      OP_WRITE = 4'h6,
      OP_PD_ENTER = 4'h7,
      OP_PD_EXIT = 4'h8,
      OP_HIB_OFF_ENTER = 4'h9,
      OP_HIB_OFF_EXIT = 4'hA
   } op_t;

   typedef enum logic [2:0] {
      CMD_NOP = 3'h0,
      CMD_ACTIVATE = 3'h1,
      CMD_PRECHARGE = 3'h2,
      CMD_REFRESH_ALL = 3'h3,
      CMD_MODE_WRITE = 3'h4,
      CMD_READ = 3'h5,
      CMD_WRITE = 3'h6,
      CMD_TRAIN = 3'h7
   } cmd_t;

   typedef struct packed {
      cmd_t cmd;
      logic [1:0] chan;
      logic [15:0] arg;
   } dev_cmd_t;

   typedef enum logic [15:0] {
      ST_IDLE = 16'h0001,
      ST_GAP = 16'h0002,
      ST_PD_NOP = 16'h0004,
      ST_PD = 16'h0008,
      ST_PD_EXIT = 16'h0010,
      ST_TRAIN = 16'h0020,
      ST_HIB_MR7 = 16'h0040,
      ST_HIB_MODE_REGISTER_TWELVE = 16'h0080,
      ST_SRE_NOP = 16'h0100,
      ST_VOFF = 16'h0200,
      ST_OFF = 16'h0400,
      ST_SUPPLY_ON = 16'h0800,
      ST_HEX = 16'h1000,
      ST_HIB_LOW = 16'h2000,
      ST_HIB_HOLD = 16'h4000,
      ST_SR_EXIT = 16'h8000
   } state_t;

endpackage

// ### dram_power_host.sv
// Notes on behaviour
// R1 - Supply-off request bit clears itself; set it by mode write before every entry.
// R2 - Device reports supply-off hibernate support in bit 15 of first vendor word.
// R3 - Write supply-off and hibernate bits on both channels, then wait mode update.
// R4 - After self refresh entry only no-ops for command disable delay.
// R5 - Device returns to ordinary hibernate once supply is stable at 0.9 core.
// R6 - Clock-enable high within receiver delay of stable supply, held through hibernate exit.
// R7 - Leave hibernate only after hibernate exit delay, then normal exit procedure.
// R8 - Clock-enable stays low from read or write until that burst completes.
// R9 - Read done when data and CRC left; write done when stored, CRC returned.
// R10 - Clock-enable stays low for each command type's own gap after the command.
// R11 - Device enters precharge or active power-down when clock-enable sampled high after low.
// R12 - Power-down disables buffers; low-power option also disables data clock and error pin.
// R13 - Low-power option clear: data clocks keep running in power-down.
// R14 - In power-down keep clock-enable high, command clock stable, reset released.
// R15 - Exit power-down with clock-enable low plus no-op, then wait exit delay.
// R16 - If PLL was off, train and wait lock time after power-down exit.
// R17 - After power-down entry only no-ops for command disable delay.
// R18 - Every clock-enable high or low pulse lasts at least the minimum width.
// R19 - Device ignores commands while clock-enable is high on two edges.
// R20 - Rising clock-enable with refresh-all while idle enters self refresh.
// R21 - Unlisted clock-enable transitions and pairings are illegal.
// R22 - After self refresh exit only no-ops during self refresh exit delay.
// R23 - Power-down residency is limited to the maximum duration.
// R24 - Hibernate request bit clears itself; set it before each hibernate entry.
// R25 - Device tracks each channel's power state separately.
//
// Chosen here: the register addresses and the APB register port.
`timescale 1ns/1ps
module dram_power_host #(
   parameter int HIB_EXIT_CYC = dram_pm_pkg::HIB_EXIT_CYC,
   parameter int HIB_HOLD_CYC = dram_pm_pkg::HIB_HOLD_CYC
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic io_supply_stable,
   output logic cke_n,
   output dram_pm_pkg::dev_cmd_t dev_cmd,
   output logic data_clock_en,
   output logic pll_en,
   output logic io_supply_en
);

   localparam int TW = 16;

   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   dram_pm_pkg::state_t state_q;
   dram_pm_pkg::op_t op_q;
   dram_pm_pkg::dev_cmd_t cmd_q;
   logic [TW-1:0] timer_q;
   logic [TW-1:0] pulse_q;
   logic cke_n_q;
   logic data_clock_en_q;
   logic pll_en_q;
   logic io_supply_en_q;
   logic [15:0] arg_q;
   logic [3:0] cfg_q;
   logic err_q;
   logic [31:0] prdata_q;
   logic pready_q;
   logic pslverr_q;
   logic stable_meta_q;
   logic stable_q;
   logic wr_en;
   logic op_go;
   logic op_ok;
   logic pulse_ok;
   logic timer_done;
   logic busy;
   logic addr_hit;
   dram_pm_pkg::op_t op_in;

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign cke_n = cke_n_q;
   assign dev_cmd = cmd_q;
   assign data_clock_en = data_clock_en_q;
   assign pll_en = pll_en_q;
   assign io_supply_en = io_supply_en_q;

   // ---------------------------------------------------------------
   // Supply-stable pin synchroniser
   // ---------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stable_meta_q <= 1'b0;
         stable_q <= 1'b0;
      end else begin
         stable_meta_q <= io_supply_stable;
         stable_q <= stable_meta_q;
      end
   end

   // ---------------------------------------------------------------
   // APB slave
   // ---------------------------------------------------------------
   // Zero wait: answer latched in the setup cycle
   // so every bus output comes from a flip-flop
   assign wr_en = psel && penable && pready_q && pwrite && !pslverr_q;
   assign addr_hit = (paddr == dram_pm_pkg::OP_OFFSET) || (paddr == dram_pm_pkg::ARG_OFFSET) ||
                     (paddr == dram_pm_pkg::CFG_OFFSET) || (paddr == dram_pm_pkg::STATUS_OFFSET);
   assign op_in = dram_pm_pkg::op_t'(pwdata[3:0]);
   assign op_go = wr_en && (paddr == dram_pm_pkg::OP_OFFSET);
   assign timer_done = (timer_q == '0);
   assign pulse_ok = (pulse_q >= TW'(dram_pm_pkg::PULSE_MIN_CYC)); // see R18
   assign busy = !((state_q == dram_pm_pkg::ST_IDLE) && pulse_ok);

   always_comb begin
      case (state_q)
         dram_pm_pkg::ST_IDLE: op_ok = pulse_ok && (op_in != dram_pm_pkg::OP_NONE) &&
                                       (op_in != dram_pm_pkg::OP_PD_EXIT) &&
                                       (op_in != dram_pm_pkg::OP_HIB_OFF_EXIT);
         dram_pm_pkg::ST_PD: op_ok = (op_in == dram_pm_pkg::OP_PD_EXIT);
         dram_pm_pkg::ST_OFF: op_ok = timer_done && (op_in == dram_pm_pkg::OP_HIB_OFF_EXIT);
         default: op_ok = 1'b0;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
      end else begin
         pready_q <= psel && !penable;
         pslverr_q <= psel && !penable && !addr_hit;
         if (psel && !penable) begin
            case (paddr)
               dram_pm_pkg::OP_OFFSET: prdata_q <= {28'h0000000, op_q};
               dram_pm_pkg::ARG_OFFSET: prdata_q <= {16'h0000, arg_q};
               dram_pm_pkg::CFG_OFFSET: prdata_q <= {28'h0000000, cfg_q};
               dram_pm_pkg::STATUS_OFFSET: prdata_q <= {13'h0000, stable_q, err_q, busy, state_q};
               default: prdata_q <= 32'h0000_0000;
            endcase
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         arg_q <= dram_pm_pkg::ARG_RESET;
         cfg_q <= dram_pm_pkg::CFG_RESET;
      end else if (wr_en) begin
         if (paddr == dram_pm_pkg::ARG_OFFSET) begin
            arg_q <= pwdata[15:0];
         end
         if (paddr == dram_pm_pkg::CFG_OFFSET) begin
            cfg_q <= pwdata[3:0];
         end
      end
   end

   // Refused orders set a sticky error; a new refusal beats the clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         err_q <= 1'b0;
      end else if (op_go && !op_ok) begin
         err_q <= 1'b1;
      end else if (wr_en && (paddr == dram_pm_pkg::STATUS_OFFSET) && pwdata[dram_pm_pkg::STATUS_ERR_BIT]) begin
         err_q <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Power-state sequencer
   // ---------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= dram_pm_pkg::ST_IDLE;
         op_q <= dram_pm_pkg::OP_NONE;
         cmd_q <= '0;
         timer_q <= '0;
         pulse_q <= '0;
         cke_n_q <= 1'b0;
         data_clock_en_q <= 1'b1;
         pll_en_q <= 1'b1;
         io_supply_en_q <= 1'b1;
      end else begin
         // No-op unless a state issues a command
         cmd_q.cmd <= dram_pm_pkg::CMD_NOP;
         if (!timer_done) begin
            timer_q <= timer_q - 1'b1;
         end
         if (!pulse_ok) begin
            pulse_q <= pulse_q + 1'b1;
         end
         if (op_go && op_ok) begin
            op_q <= op_in;
         end
         case (state_q)
            dram_pm_pkg::ST_IDLE: begin
               if (op_go && op_ok) begin
                  cmd_q.chan <= cfg_q[dram_pm_pkg::CFG_CHAN_LSB +: 2];
                  cmd_q.arg <= arg_q;
                  state_q <= dram_pm_pkg::ST_GAP;
                  case (op_in)
                     dram_pm_pkg::OP_ACTIVATE: begin
                        cmd_q.cmd <= dram_pm_pkg::CMD_ACTIVATE;
                        timer_q <= TW'(dram_pm_pkg::ACT_GAP_CYC); // see R10
                     end
                     dram_pm_pkg::OP_PRECHARGE: begin
                        cmd_q.cmd <= dram_pm_pkg::CMD_PRECHARGE;
                        timer_q <= TW'(dram_pm_pkg::PRE_GAP_CYC); // see R10
                     end
                     dram_pm_pkg::OP_REFRESH: begin
                        cmd_q.cmd <= dram_pm_pkg::CMD_REFRESH_ALL;
                        timer_q <= TW'(dram_pm_pkg::REF_GAP_CYC); // see R10
                     end
                     dram_pm_pkg::OP_MODE_WRITE: begin
                        cmd_q.cmd <= dram_pm_pkg::CMD_MODE_WRITE;
                        timer_q <= TW'(dram_pm_pkg::MRS_GAP_CYC); // see R10
                     end
                     dram_pm_pkg::OP_READ: begin
                        cmd_q.cmd <= dram_pm_pkg::CMD_READ;
                        timer_q <= TW'(dram_pm_pkg::READ_DONE_CYC); // see R8
                     end
                     dram_pm_pkg::OP_WRITE: begin
                        cmd_q.cmd <= dram_pm_pkg::CMD_WRITE;
                        timer_q <= TW'(dram_pm_pkg::WRITE_DONE_CYC); // see R8
                     end
                     dram_pm_pkg::OP_PD_ENTER: begin
                        // Rising clock-enable with a no-op enters power-down
                        cke_n_q <= 1'b1; // see R11
                        pulse_q <= '0;
                        timer_q <= TW'(dram_pm_pkg::CMD_DISABLE_CYC); // see R17
                        state_q <= dram_pm_pkg::ST_PD_NOP;
                        if (cfg_q[dram_pm_pkg::CFG_LOW_POWER_BIT]) begin
                           data_clock_en_q <= 1'b0; // see R12
                        end
                        if (cfg_q[dram_pm_pkg::CFG_PLL_OFF_BIT]) begin
                           pll_en_q <= 1'b0;
                        end
                     end
                     default: begin
                        // Hibernate request first, supply-off request next
                        cmd_q.cmd <= dram_pm_pkg::CMD_MODE_WRITE;
                        cmd_q.chan <= dram_pm_pkg::BOTH_CHANNELS;
                        cmd_q.arg <= dram_pm_pkg::MR7_HIBERNATE_ARG; // see R24
                        timer_q <= TW'(dram_pm_pkg::MODE_UPDATE_CYC); // see R3
                        state_q <= dram_pm_pkg::ST_HIB_MR7;
                     end
                  endcase
               end
            end
            dram_pm_pkg::ST_GAP: begin
               if (timer_done) begin
                  state_q <= dram_pm_pkg::ST_IDLE;
               end
            end
            dram_pm_pkg::ST_PD_NOP: begin
               if (timer_done) begin
                  timer_q <= TW'(dram_pm_pkg::PD_MAX_CYC);
                  state_q <= dram_pm_pkg::ST_PD;
               end
            end
            dram_pm_pkg::ST_PD: begin
               // Clock-enable held high here; timeout forces the exit
               if ((timer_done || (op_go && op_ok)) && pulse_ok) begin // see R14, R23
                  cke_n_q <= 1'b0; // see R15
                  pulse_q <= '0;
                  timer_q <= TW'(dram_pm_pkg::PD_EXIT_CYC); // see R15
                  data_clock_en_q <= 1'b1; // see R13
                  state_q <= dram_pm_pkg::ST_PD_EXIT;
               end
            end
            dram_pm_pkg::ST_PD_EXIT: begin
               if (timer_done) begin
                  if (!pll_en_q) begin
                     pll_en_q <= 1'b1;
                     cmd_q.cmd <= dram_pm_pkg::CMD_TRAIN; // see R16
                     timer_q <= TW'(dram_pm_pkg::PLL_LOCK_CYC); // see R16
                     state_q <= dram_pm_pkg::ST_TRAIN;
                  end else begin
                     state_q <= dram_pm_pkg::ST_IDLE;
                  end
               end
            end
            dram_pm_pkg::ST_TRAIN: begin
               if (timer_done) begin
                  state_q <= dram_pm_pkg::ST_IDLE;
               end
            end
            dram_pm_pkg::ST_HIB_MR7: begin
               if (timer_done) begin
                  cmd_q.cmd <= dram_pm_pkg::CMD_MODE_WRITE;
                  cmd_q.arg <= dram_pm_pkg::MODE_REGISTER_TWELVE_SUPPLY_OFF_ARG; // see R1
                  timer_q <= TW'(dram_pm_pkg::MODE_UPDATE_CYC); // see R3
                  state_q <= dram_pm_pkg::ST_HIB_MODE_REGISTER_TWELVE;
               end
            end
            dram_pm_pkg::ST_HIB_MODE_REGISTER_TWELVE: begin
               if (timer_done && pulse_ok) begin
                  cke_n_q <= 1'b1; // see R20
                  pulse_q <= '0;
                  cmd_q.cmd <= dram_pm_pkg::CMD_REFRESH_ALL; // see R20
                  timer_q <= TW'(dram_pm_pkg::CMD_DISABLE_CYC); // see R4
                  state_q <= dram_pm_pkg::ST_SRE_NOP;
               end
            end
            dram_pm_pkg::ST_SRE_NOP: begin
               if (timer_done) begin
                  timer_q <= TW'(dram_pm_pkg::SUPPLY_WAIT_CYC);
                  state_q <= dram_pm_pkg::ST_VOFF;
               end
            end
            dram_pm_pkg::ST_VOFF: begin
               if (timer_done) begin
                  io_supply_en_q <= 1'b0;
                  data_clock_en_q <= 1'b0;
                  timer_q <= TW'(dram_pm_pkg::SUPPLY_OFF_MIN_CYC);
                  state_q <= dram_pm_pkg::ST_OFF;
               end
            end
            dram_pm_pkg::ST_OFF: begin
               if (op_go && op_ok) begin
                  io_supply_en_q <= 1'b1;
                  state_q <= dram_pm_pkg::ST_SUPPLY_ON;
               end
            end
            dram_pm_pkg::ST_SUPPLY_ON: begin
               // Clock-enable stays high, so the receiver delay is met
               if (stable_q) begin
                  timer_q <= TW'(HIB_EXIT_CYC); // see R6
                  state_q <= dram_pm_pkg::ST_HEX;
               end
            end
            dram_pm_pkg::ST_HEX: begin
               if (timer_done) begin
                  cke_n_q <= 1'b0; // see R7
                  pulse_q <= '0;
                  timer_q <= TW'(dram_pm_pkg::HIB_LOW_CYC);
                  state_q <= dram_pm_pkg::ST_HIB_LOW;
               end
            end
            dram_pm_pkg::ST_HIB_LOW: begin
               if (timer_done && pulse_ok) begin
                  cke_n_q <= 1'b1;
                  pulse_q <= '0;
                  timer_q <= TW'(HIB_HOLD_CYC);
                  state_q <= dram_pm_pkg::ST_HIB_HOLD;
               end
            end
            dram_pm_pkg::ST_HIB_HOLD: begin
               if (timer_done && pulse_ok) begin
                  cke_n_q <= 1'b0;
                  pulse_q <= '0;
                  data_clock_en_q <= 1'b1;
                  timer_q <= TW'(dram_pm_pkg::SR_EXIT_CYC); // see R22
                  state_q <= dram_pm_pkg::ST_SR_EXIT;
               end
            end
            dram_pm_pkg::ST_SR_EXIT: begin
               if (timer_done) begin
                  state_q <= dram_pm_pkg::ST_IDLE;
               end
            end
            default: begin
               state_q <= dram_pm_pkg::ST_IDLE;
            end
         endcase
      end
   end

endmodule

// ### dram_dev_model.sv
`timescale 1ns/1ps
module dram_dev_model #(
   parameter logic [15:0] VENDOR_ID1 = 16'h8000 // bit 15 set, other bits arbitrary
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic cke_n,
   input wire dram_pm_pkg::dev_cmd_t dev_cmd,
   input wire logic data_clock_en,
   input wire logic io_supply_en,
   output logic io_supply_stable,
   output logic edc_level
);
   // Power state per channel: 0 run, 1 pre pd, 2 act pd, 3 self ref, 4 hib, 5 supply off
   logic [2:0] st_q [2];
   logic cke_prev_q, row_q, hib_q, off_q;
   logic [3:0] sup_q;
   // Stable four edges after supply on
   assign io_supply_stable = &sup_q;
   // Pin toggles while the data clock runs
   assign edc_level = data_clock_en ? pclk : 1'b1;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sup_q <= 4'hF;
         st_q <= '{3'h0, 3'h0};
      end else begin
         sup_q <= io_supply_en ? {sup_q[2:0], 1'b1} : 4'h0;
         for (int ch = 0; ch < 2; ch++) begin
            if (!cke_prev_q && cke_n) begin
               st_q[ch] <= (dev_cmd.cmd === dram_pm_pkg::CMD_REFRESH_ALL) ? (hib_q ? 3'h4 : 3'h3) : (row_q ? 3'h2 : 3'h1);
            end else if (cke_prev_q && !cke_n && st_q[ch] < 3'h4) begin
               st_q[ch] <= 3'h0;
            end else if (st_q[ch] == 3'h4 && off_q && !io_supply_en) begin
               st_q[ch] <= 3'h5;
            end else if (st_q[ch] == 3'h5 && io_supply_stable) begin
               st_q[ch] <= 3'h4;
            end // Two high edges ignore commands; only supply changes still move hibernate and supply off
         end
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {cke_prev_q, row_q, hib_q, off_q} <= 4'h0;
      end else begin
         cke_prev_q <= cke_n;
         if (dev_cmd.cmd === dram_pm_pkg::CMD_ACTIVATE) row_q <= 1'b1;
         if (dev_cmd.cmd === dram_pm_pkg::CMD_PRECHARGE) row_q <= 1'b0;
         // Request bits clear themselves once used
         if (dev_cmd.cmd === dram_pm_pkg::CMD_MODE_WRITE && dev_cmd.arg === 16'h7002) hib_q <= 1'b1;
         if (dev_cmd.cmd === dram_pm_pkg::CMD_MODE_WRITE && dev_cmd.arg === 16'hC001) off_q <= 1'b1;
         if (!cke_prev_q && cke_n) hib_q <= 1'b0;
         if (!io_supply_en) off_q <= 1'b0;
      end
   end
endmodule

// ### dram_power_host_chk.sv
`timescale 1ns/1ps
module dram_power_host_chk #(
   parameter int HIB_EXIT_CYC = 20,
   parameter int HIB_HOLD_CYC = 20
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic cke_n,
   input wire dram_pm_pkg::dev_cmd_t dev_cmd,
   input wire logic data_clock_en,
   input wire logic pll_en,
   input wire logic io_supply_en
);
   // Counts power-down residency while the data clock runs
   int pd_cnt_q;
   dram_pm_pkg::cmd_t c;
   assign c = dev_cmd.cmd;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) pd_cnt_q <= 0;
      else pd_cnt_q <= (cke_n && data_clock_en) ? pd_cnt_q + 1 : 0;
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_read_low: assert property (c == dram_pm_pkg::CMD_READ |-> !cke_n [*6]) else $error("enable high in read");
   a_write_low: assert property (c == dram_pm_pkg::CMD_WRITE |-> !cke_n [*8]) else $error("enable high in write");
   a_gap_low: assert property (c inside {3'h1, 3'h2, 3'h4} |-> !cke_n [*2]) else $error("gap too short");
   a_entry_nop: assert property ($rose(cke_n) |=> c == dram_pm_pkg::CMD_NOP) else $error("command after entry");
   a_exit_nop: assert property ($fell(cke_n) |-> c == dram_pm_pkg::CMD_NOP [*2]) else $error("command in exit");
   a_off_high: assert property (!io_supply_en |-> cke_n && !data_clock_en) else $error("enable low at off");
   a_supply_hold: assert property ($rose(io_supply_en) |-> cke_n [*8]) else $error("enable low too soon");
   a_train_pll: assert property (c == dram_pm_pkg::CMD_TRAIN |-> pll_en && !cke_n) else $error("train bad");
   a_pd_limit: assert property (pd_cnt_q <= dram_pm_pkg::PD_MAX_CYC + 4) else $error("power-down too long");
   a_hib_order: assert property (c == dram_pm_pkg::CMD_MODE_WRITE && dev_cmd.arg == 16'hC001
      |-> ##[1:4] (c == dram_pm_pkg::CMD_REFRESH_ALL && cke_n && dev_cmd.chan == 2'h3)) else $error("bad entry");
   c_read: cover property (c == dram_pm_pkg::CMD_READ);
   c_train: cover property (c == dram_pm_pkg::CMD_TRAIN);
   c_off: cover property (!io_supply_en);
endmodule

// ### dram_power_host_tb.sv
`timescale 1ns/1ps
`define CHK(a, x) begin check_count++; if ((a) !== (x)) begin n_errors++; $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, x); end end
module dram_power_host_tb;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, e;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, io_supply_stable, cke_n, data_clock_en, pll_en, io_supply_en;
   dram_pm_pkg::dev_cmd_t dev_cmd;
   int n_errors = 0, check_count = 0;
   always #20 pclk = ~pclk;
   dram_power_host #(.HIB_EXIT_CYC(20), .HIB_HOLD_CYC(20)) uut (.*);
   dram_dev_model dev (.pclk(pclk), .presetn(presetn), .cke_n(cke_n), .dev_cmd(dev_cmd), .data_clock_en(data_clock_en),
      .io_supply_en(io_supply_en), .io_supply_stable(io_supply_stable), .edc_level());
   // ---------------------------------------------------------------
   // Bus and helpers
   // ---------------------------------------------------------------
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1 && n++ < 20);
      rd = prdata;
      e = pslverr;
      {psel, penable} <= 2'b00;
   endtask
   // Bound guards a hang
   task automatic wait_idle(input int lim);
      int n;
      n = 0;
      do apb(1'b0, dram_pm_pkg::STATUS_OFFSET, 32'h0); while (!(rd[0] === 1'b1 && rd[16] === 1'b0) && n++ < lim);
      `CHK(rd[0], 1'b1)
   endtask
   task automatic op(input logic [3:0] o);
      apb(1'b1, dram_pm_pkg::OP_OFFSET, {28'h0, o});
      @(posedge pclk);
   endtask
   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_refuse();
      apb(1'b0, 12'h010, 32'h0);
      `CHK({e, rd}, 33'h100000000)
      op(4'h8);
      apb(1'b0, dram_pm_pkg::STATUS_OFFSET, 32'h0);
      `CHK(rd[17], 1'b1)
      apb(1'b1, dram_pm_pkg::STATUS_OFFSET, 32'h00020000);
      apb(1'b0, dram_pm_pkg::STATUS_OFFSET, 32'h0);
      `CHK(rd[17], 1'b0)
   endtask
   task automatic t_cmds();
      for (int i = 1; i <= 6; i++) begin
         apb(1'b1, dram_pm_pkg::ARG_OFFSET, 32'h00005ABC);
         op(4'(i));
         `CHK(dev_cmd.cmd, 3'(i))
         `CHK({cke_n, dev_cmd.arg}, 17'h05ABC)
         wait_idle(20);
      end
   endtask
   task automatic t_pd(input logic [31:0] cfg, input int lim);
      apb(1'b1, dram_pm_pkg::CFG_OFFSET, cfg);
      op(4'h7);
      `CHK({cke_n, data_clock_en, pll_en}, {1'b1, ~cfg[0], ~cfg[1]})
      if (cfg[0]) op(4'h8);
      wait_idle(lim);
      `CHK({cke_n, data_clock_en, pll_en}, 3'h3)
   endtask
   task automatic t_hib();
      apb(1'b1, dram_pm_pkg::CFG_OFFSET, 32'h0);
      op(4'h9);
      for (int n = 0; n < 60 && io_supply_en !== 1'b0; n++) @(posedge pclk);
      @(posedge pclk);
      `CHK({io_supply_en, cke_n, io_supply_stable}, 3'h2)
      op(4'hA);
      apb(1'b0, dram_pm_pkg::STATUS_OFFSET, 32'h0);
      `CHK({rd[17], io_supply_en}, 2'h2)
      repeat (30) @(posedge pclk);
      op(4'hA);
      repeat (8) @(posedge pclk);
      `CHK({io_supply_en, cke_n}, 2'h3)
      wait_idle(200);
      `CHK({cke_n, data_clock_en}, 2'h1)
   endtask
   task automatic finish_test();
      if (n_errors == 0 && check_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   initial begin
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      t_refuse();
      t_cmds();
      t_pd(32'h3, 1200);
      t_pd(32'h0, 150);
      t_hib();
      finish_test();
   end
   initial begin
      repeat (20000) @(posedge pclk);
      n_errors++;
      finish_test();
   end
endmodule
bind dram_power_host dram_power_host_chk #(.HIB_EXIT_CYC(HIB_EXIT_CYC), .HIB_HOLD_CYC(HIB_HOLD_CYC)) chk (.pclk(pclk),
   .presetn(presetn), .cke_n(cke_n), .dev_cmd(dev_cmd), .data_clock_en(data_clock_en), .pll_en(pll_en),
   .io_supply_en(io_supply_en));
